// ### common/fsq_pkg.sv
// Constants shared by the flash sequencer, its step timer and the bench.
// Assumes one 10 MHz clock and a flash cell macro with two interleaved banks.
package fsq_pkg;

  // ==========================================================
  // Array geometry
  localparam int WORD_W = 32;       // Processor data path width
  localparam int ADDR_W = 17;       // Word address over 512 kB
  localparam int BLK_NUM = 4;       // Independently writable blocks
  localparam int BLK_LSB = 15;      // 128 kB block = 32K words
  localparam int BANK_NUM = 2;      // Interleaved banks, word lsb selects
  localparam int ROW_W = 16;        // Word address inside one bank

  // ==========================================================
  // Command codes
  localparam logic [2:0] OP_PGM = 3'h1;       // Program one word
  localparam logic [2:0] OP_ERS_BLK = 3'h2;   // Erase one block
  localparam logic [2:0] OP_ERS_CHIP = 3'h3;  // Erase all blocks
  localparam logic [2:0] OP_PROT = 3'h4;      // Protect one block
  localparam logic [2:0] OP_UNPROT = 3'h5;    // Erase chip, drop protection

  // ==========================================================
  // Reset values
  localparam logic [3:0] PROT_RST = 4'h0;
  localparam logic [WORD_W-1:0] DATA_RST = 32'h0000_0000;

  // ==========================================================
  // Timing
  localparam int TMR_W = 23;
  localparam int CLK_NS = 100;               // 10 MHz system clock
  localparam int T_PGM_NS = 15000;           // One word program step
  localparam int T_ERS_BLK_MS = 100;         // One block erase
  localparam int T_ERS_CHIP_MS = 400;        // Whole chip erase
  localparam int NS_PER_MS = 1000000;
  localparam logic [TMR_W-1:0] PGM_CYC =
    TMR_W'((T_PGM_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] ERS_BLK_CYC_DEF =
    TMR_W'(T_ERS_BLK_MS * (NS_PER_MS / CLK_NS));
  localparam logic [TMR_W-1:0] ERS_CHIP_CYC_DEF =
    TMR_W'(T_ERS_CHIP_MS * (NS_PER_MS / CLK_NS));

  // ==========================================================
  // Sequencer states, Gray along idle, run, done
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_RUN = 2'h1,
    S_DONE = 2'h3
  } fsq_state_e;

endpackage

// ### rtl/fsq_step_timer.sv
// Down counter that times one program or erase step.
// Assumes the loader holds off a new load until done has pulsed.
module fsq_step_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [fsq_pkg::TMR_W-1:0] load_val,
  output logic done
);

  // Remaining cycles of the step, zero while idle
  logic [fsq_pkg::TMR_W-1:0] cnt;

  // ==========================================================
  // Count
  // Load wins; otherwise count down to zero and park there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // Last cycle of the step, so the step lasts exactly load_val cycles
  assign done = (cnt == fsq_pkg::TMR_W'(1));

endmodule

// ### rtl/fsq_flash_ctrl.sv
// Flash sequencer: boot mode capture, interleaved reads, automatic
// program and erase, block protection and read protection.
// Assumes a flash cell macro that returns read data one cycle after
// its bank read enable, and programs or erases while its enables stand.
module fsq_flash_ctrl #(
  parameter logic [fsq_pkg::TMR_W-1:0] ERS_BLK_CYC = fsq_pkg::ERS_BLK_CYC_DEF,
  parameter logic [fsq_pkg::TMR_W-1:0] ERS_CHIP_CYC = fsq_pkg::ERS_CHIP_CYC_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic boot_pin,
  output logic mode_valid,
  output logic boot_from_rom,
  input wire logic cpu_req,
  input wire logic [fsq_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic ext_req,
  input wire logic [fsq_pkg::ADDR_W-1:0] ext_addr,
  output logic rd_ready,
  output logic [fsq_pkg::WORD_W-1:0] rd_data,
  output logic cpu_rvalid,
  output logic ext_rvalid,
  output logic ext_denied,
  output logic [fsq_pkg::BANK_NUM-1:0] arr_rd_en,
  output logic [fsq_pkg::BANK_NUM-1:0][fsq_pkg::ROW_W-1:0] arr_rd_addr,
  input wire logic [fsq_pkg::BANK_NUM-1:0][fsq_pkg::WORD_W-1:0] arr_rdata,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic [fsq_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [fsq_pkg::WORD_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_err,
  output logic busy,
  output logic arr_pgm_en,
  output logic [fsq_pkg::ADDR_W-1:0] arr_pgm_addr,
  output logic [fsq_pkg::WORD_W-1:0] arr_wdata,
  output logic arr_ers_en,
  output logic arr_ers_all,
  output logic [1:0] arr_ers_blk,
  output logic [fsq_pkg::BLK_NUM-1:0] blk_prot,
  output logic read_prot
);

  // ==========================================================
  // Boot mode capture
  logic boot_s1;  // First synchroniser stage
  logic boot_s2;  // Second stage, safe to read

  // No reset here so the pin is already settled when reset lifts
  always_ff @(posedge clk) begin
    boot_s1 <= boot_pin;
    boot_s2 <= boot_s1;
  end

  // Catch the level once, on the first edge after release; later pin
  // moves are ignored, since a mode change mid-run would be fatal
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_valid <= 1'b0;
      boot_from_rom <= 1'b0;
    end else if (!mode_valid) begin
      mode_valid <= 1'b1;
      boot_from_rom <= !boot_s2;       // Pin 0 boot ROM; user boot is code's
    end
  end

  // ==========================================================
  // Sequencer state and command acceptance
  fsq_pkg::fsq_state_e state;
  logic [2:0] op_q;                    // Command being run
  logic [1:0] blk_q;                   // Block of that command
  logic tmr_done;                      // Last cycle of a timed step
  logic rd_take;                       // Read accepted this cycle
  logic cmd_take;                      // Command accepted this cycle
  logic cmd_bad;                       // Accepted command is refused
  logic [1:0] cmd_blk;                 // Block addressed by the command
  logic [fsq_pkg::BLK_NUM-1:0] cmd_blk_mask;
  logic [fsq_pkg::TMR_W-1:0] tmr_val;  // Step length for this command

  assign cmd_blk = cmd_addr[fsq_pkg::BLK_LSB +: 2];
  assign cmd_blk_mask = fsq_pkg::BLK_NUM'(1) << cmd_blk;
  // Reads first; nothing accepted while a step runs
  assign rd_ready = mode_valid && (state == fsq_pkg::S_IDLE);
  assign rd_take = rd_ready && (cpu_req || ext_req);
  assign cmd_ready = rd_ready && !cpu_req && !ext_req;
  assign cmd_take = cmd_valid && cmd_ready;
  assign busy = (state != fsq_pkg::S_IDLE);
  // Read protection follows the protect bits, no separate switch
  assign read_prot = &blk_prot;

  // Refusals: unknown codes, no multi-block form but the chip
  // and writes into protected blocks; protection moves only here
  always_comb begin
    cmd_bad = 1'b0;
    tmr_val = fsq_pkg::PGM_CYC;
    case (cmd_op)
      fsq_pkg::OP_PGM: begin
        cmd_bad = |(blk_prot & cmd_blk_mask);
      end
      fsq_pkg::OP_ERS_BLK: begin
        cmd_bad = |(blk_prot & cmd_blk_mask);
        tmr_val = ERS_BLK_CYC;
      end
      fsq_pkg::OP_ERS_CHIP: begin
        cmd_bad = |blk_prot;
        tmr_val = ERS_CHIP_CYC;
      end
      fsq_pkg::OP_PROT: begin
        cmd_bad = 1'b0;
      end
      fsq_pkg::OP_UNPROT: begin
        tmr_val = ERS_CHIP_CYC;        // Erase runs before the clear
      end
      default: begin
        cmd_bad = 1'b1;
      end
    endcase
  end

  // Step timing is internal; the requester never times steps
  fsq_step_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(cmd_take && !cmd_bad && (cmd_op != fsq_pkg::OP_PROT)),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // State walk: a started step only ends on the timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fsq_pkg::S_IDLE;
      op_q <= 3'h0;
      blk_q <= 2'h0;
    end else begin
      case (state)
        fsq_pkg::S_IDLE: begin
          if (cmd_take && !cmd_bad) begin
            op_q <= cmd_op;
            blk_q <= cmd_blk;
            // Protect needs no array step
            state <= (cmd_op == fsq_pkg::OP_PROT) ? fsq_pkg::S_DONE : fsq_pkg::S_RUN;
          end
        end
        fsq_pkg::S_RUN: begin
          if (tmr_done) begin
            state <= fsq_pkg::S_DONE;
          end
        end
        default: begin
          state <= fsq_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Completion and refusal pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_done <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      cmd_done <= (state == fsq_pkg::S_DONE);
      cmd_err <= cmd_take && cmd_bad;
    end
  end

  // ==========================================================
  // Array program and erase drive, held for the whole step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arr_pgm_en <= 1'b0;
      arr_pgm_addr <= '0;
      arr_wdata <= fsq_pkg::DATA_RST;
      arr_ers_en <= 1'b0;
      arr_ers_all <= 1'b0;
      arr_ers_blk <= 2'h0;
    end else if (cmd_take && !cmd_bad) begin
      arr_pgm_en <= (cmd_op == fsq_pkg::OP_PGM);
      arr_pgm_addr <= cmd_addr;
      arr_wdata <= cmd_wdata;
      arr_ers_en <= (cmd_op == fsq_pkg::OP_ERS_BLK);
      arr_ers_all <= (cmd_op == fsq_pkg::OP_ERS_CHIP) ||
                     (cmd_op == fsq_pkg::OP_UNPROT);
      arr_ers_blk <= cmd_blk;
    end else if (state == fsq_pkg::S_RUN && tmr_done) begin
      arr_pgm_en <= 1'b0;
      arr_ers_en <= 1'b0;
      arr_ers_all <= 1'b0;
    end
  end

  // ==========================================================
  // Protection bits; volatile here, cleared by reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_prot <= fsq_pkg::PROT_RST;
    end else if (state == fsq_pkg::S_DONE) begin
      if (op_q == fsq_pkg::OP_PROT) begin
        blk_prot[blk_q] <= 1'b1;
      end else if (op_q == fsq_pkg::OP_UNPROT) begin
        blk_prot <= fsq_pkg::PROT_RST;     // Only after the chip erase
      end
    end
  end

  // ==========================================================
  // Interleaved read pipeline: take, array, data
  logic [fsq_pkg::ADDR_W-1:0] rd_addr;  // Winning address
  logic rd_ext;                         // Winner is the external programmer
  logic p1_val, p1_ext, p1_bank;        // Array cycle
  logic p2_val, p2_ext, p2_bank;        // Data return cycle

  assign rd_ext = !cpu_req;             // Processor has priority
  assign rd_addr = rd_ext ? ext_addr : cpu_addr;

  // Word lsb picks the bank, so sequential fetches alternate banks
  for (genvar b = 0; b < fsq_pkg::BANK_NUM; b++) begin : g_bank
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        arr_rd_en[b] <= 1'b0;
        arr_rd_addr[b] <= '0;
      end else begin
        // A protected external read never reaches the array
        arr_rd_en[b] <= rd_take && (rd_addr[0] == 1'(b)) && !(rd_ext && read_prot);
        if (rd_take && (rd_addr[0] == 1'(b))) begin
          arr_rd_addr[b] <= rd_addr[fsq_pkg::ADDR_W-1:1];
        end
      end
    end
  end

  // Pipeline tags and the returned word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1_val <= 1'b0;
      p1_ext <= 1'b0;
      p1_bank <= 1'b0;
      p2_val <= 1'b0;
      p2_ext <= 1'b0;
      p2_bank <= 1'b0;
      ext_denied <= 1'b0;
      rd_data <= fsq_pkg::DATA_RST;
      cpu_rvalid <= 1'b0;
      ext_rvalid <= 1'b0;
    end else begin
      p1_val <= rd_take && !(rd_ext && read_prot);
      p1_ext <= rd_ext;
      p1_bank <= rd_addr[0];
      ext_denied <= rd_take && rd_ext && read_prot;
      p2_val <= p1_val;
      p2_ext <= p1_ext;
      p2_bank <= p1_bank;
      if (p2_val) begin
        rd_data <= arr_rdata[p2_bank];
      end
      cpu_rvalid <= p2_val && !p2_ext;
      ext_rvalid <= p2_val && p2_ext;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_mode_frozen_after: assert property (
    mode_valid && $past(mode_valid) |-> $stable(boot_from_rom))
    else $error("boot mode changed after capture");
  a_mode_from_pin: assert property (
    $rose(mode_valid) |-> boot_from_rom == !$past(boot_s2))
    else $error("boot mode does not match pin level");
  a_no_early_read: assert property (
    !mode_valid |-> !rd_ready && !cmd_ready)
    else $error("access accepted before mode capture");
  a_cpu_read_latency: assert property (
    cpu_req && rd_ready |-> ##3 cpu_rvalid && !ext_rvalid)
    else $error("processor read not answered in three cycles");
  a_ext_read_refused: assert property (
    ext_req && !cpu_req && rd_ready && read_prot
      |=> ext_denied && arr_rd_en == '0 ##2 !ext_rvalid)
    else $error("protected external read returned data");
  a_busy_refuses_cmd: assert property (
    busy |-> !cmd_ready && !rd_ready)
    else $error("request accepted during a step");
  a_auto_read_prot: assert property (
    cmd_take && cmd_op == fsq_pkg::OP_PROT &&
      ((blk_prot | cmd_blk_mask) == 4'hF) |-> ##2 read_prot)
    else $error("read protect not set with all blocks protected");
  a_erase_before_clear: assert property (
    $fell(read_prot) |-> $past(arr_ers_all, 2))
    else $error("protection dropped without chip erase");
  a_pgm_step_held: assert property (
    $rose(arr_pgm_en) |-> (arr_pgm_en && busy)[*8])
    else $error("program step ended early");
  a_erase_kinds_apart: assert property (
    arr_ers_en |-> !arr_ers_all && !(|(blk_prot & (4'h1 << arr_ers_blk))))
    else $error("bad erase selection");

  c_cpu_read: cover property (cpu_req && rd_ready ##3 cpu_rvalid);
  c_ext_denied: cover property (ext_denied);
  c_unprotect: cover property ($fell(read_prot));
  c_boot_rom: cover property ($rose(mode_valid) && boot_from_rom);

endmodule

// ### sim/fsq_flash_array.sv
// Behavioural flash cell macro on the far side of the sequencer.
// Assumes data is wanted one cycle after a bank read enable.
module fsq_flash_array #(
  parameter logic [31:0] BLANK = 32'hffff_ffff // Erased cell value
) (
  input wire logic clk,
  input wire logic [fsq_pkg::BANK_NUM-1:0] arr_rd_en,
  input wire logic [fsq_pkg::BANK_NUM-1:0][fsq_pkg::ROW_W-1:0] arr_rd_addr,
  output logic [fsq_pkg::BANK_NUM-1:0][fsq_pkg::WORD_W-1:0] arr_rdata,
  input wire logic arr_pgm_en,
  input wire logic [fsq_pkg::ADDR_W-1:0] arr_pgm_addr,
  input wire logic [fsq_pkg::WORD_W-1:0] arr_wdata,
  input wire logic arr_ers_en,
  input wire logic arr_ers_all,
  input wire logic [1:0] arr_ers_blk
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Storage
  logic [31:0] mem [int]; // Programmed words only
  int kill [$]; // Keys of one block to wipe
  initial arr_rdata = '0;
  // Bank data one cycle after enable; toggles otherwise so stale data never matches
  always @(posedge clk) begin
    for (int b = 0; b < fsq_pkg::BANK_NUM; b++) begin
      int a;
      a = {arr_rd_addr[b], b[0]};
      if (arr_rd_en[b])
        arr_rdata[b] <= mem.exists(a) ? mem[a] : BLANK;
      else
        arr_rdata[b] <= ~arr_rdata[b];
    end
  end
  // Program and erase while the enables stand
  always @(posedge clk) begin
    if (arr_pgm_en)
      mem[int'(arr_pgm_addr)] = arr_wdata;
    if (arr_ers_all)
      mem.delete();
    else if (arr_ers_en) begin
      kill = {};
      foreach (mem[k])
        if (k[16:15] == arr_ers_blk)
          kill.push_back(k);
      foreach (kill[i])
        mem.delete(kill[i]);
    end
  end
endmodule

// ### sim/fsq_flash_ctrl_tb.sv
// Self-checking bench for the flash sequencer with a cell model.
// Assumes the short erase counts set below.
module fsq_flash_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [22:0] EB = 23'h0014; // Short block erase
  localparam logic [22:0] EC = 23'h0028; // Short chip erase
  localparam logic [31:0] BLANK = 32'hffff_ffff;
  typedef struct {
    logic [2:0] op;
    logic [16:0] a;
    logic [31:0] d;
    logic err;
    int n;
    logic [16:0] ra;
    logic [31:0] re;
  } fsq_row_s;
  // ==========================================
  // Table cases: command, then read-back, ending with two refused unknown codes
  fsq_row_s rows[6] = '{
    '{fsq_pkg::OP_PGM, 17'h0_0000, 32'h1234_5678, 1'b0, 152, 17'h0_0000, 32'h1234_5678},
    '{fsq_pkg::OP_PGM, 17'h0_0001, 32'hcafe_0001, 1'b0, 152, 17'h0_0001, 32'hcafe_0001},
    '{fsq_pkg::OP_PGM, 17'h0_8000, 32'h5a5a_a5a5, 1'b0, 152, 17'h0_8000, 32'h5a5a_a5a5},
    '{fsq_pkg::OP_ERS_BLK, 17'h0_8000, 32'h0, 1'b0, int'(EB) + 2, 17'h0_8000, BLANK},
    '{3'h0, 17'h0_0000, 32'h0, 1'b1, 1, 17'h0_0000, 32'h1234_5678},
    '{3'h7, 17'h0_0000, 32'h0, 1'b1, 1, 17'h0_0001, 32'hcafe_0001}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic boot_pin = 1'b0;
  logic cpu_req = 1'b0;
  logic ext_req = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [16:0] cpu_addr = '0;
  logic [16:0] ext_addr = '0;
  logic [16:0] cmd_addr = '0;
  logic [31:0] cmd_wdata = '0;
  logic mode_valid, boot_from_rom, rd_ready, cpu_rvalid, ext_rvalid, ext_denied;
  logic cmd_ready, cmd_done, cmd_err, busy, arr_pgm_en, arr_ers_en, arr_ers_all;
  logic read_prot;
  logic [1:0] arr_rd_en, arr_ers_blk;
  logic [1:0][15:0] arr_rd_addr;
  logic [1:0][31:0] arr_rdata;
  logic [31:0] rd_data, arr_wdata;
  logic [16:0] arr_pgm_addr;
  logic [3:0] blk_prot;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  always #50 clk = ~clk; // 10 MHz
  fsq_flash_ctrl #(.ERS_BLK_CYC(EB), .ERS_CHIP_CYC(EC)) i_fsq_flash_ctrl (
    .clk(clk), .rst_n(rst_n), .boot_pin(boot_pin), .mode_valid(mode_valid),
    .boot_from_rom(boot_from_rom), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .ext_req(ext_req), .ext_addr(ext_addr), .rd_ready(rd_ready), .rd_data(rd_data),
    .cpu_rvalid(cpu_rvalid), .ext_rvalid(ext_rvalid), .ext_denied(ext_denied),
    .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr), .arr_rdata(arr_rdata),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_err(cmd_err), .busy(busy),
    .arr_pgm_en(arr_pgm_en), .arr_pgm_addr(arr_pgm_addr), .arr_wdata(arr_wdata),
    .arr_ers_en(arr_ers_en), .arr_ers_all(arr_ers_all), .arr_ers_blk(arr_ers_blk),
    .blk_prot(blk_prot), .read_prot(read_prot));
  fsq_flash_array #(.BLANK(BLANK)) i_fsq_flash_array (
    .clk(clk), .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr),
    .arr_rdata(arr_rdata), .arr_pgm_en(arr_pgm_en), .arr_pgm_addr(arr_pgm_addr),
    .arr_wdata(arr_wdata), .arr_ers_en(arr_ers_en), .arr_ers_all(arr_ers_all),
    .arr_ers_blk(arr_ers_blk));
  // ==========================================
  // Shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // Reset long enough for the pin synchroniser, then look at the captured mode
  task automatic boot(input logic b);
    rst_n = 1'b0;
    boot_pin = b; // Held steady through reset; the main sequence moves it later
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("mode_valid", 1'b1, mode_valid);
    chk("boot_from_rom", !b, boot_from_rom);
  endtask
  // One command held until taken; counts cycles to done or refusal
  task automatic cmd(input fsq_row_s r);
    int n;
    cmd_valid = 1'b1;
    cmd_op = r.op;
    cmd_addr = r.a;
    cmd_wdata = r.d;
    while (!cmd_ready) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 1;
    while (!(cmd_done | cmd_err) && n < 200) begin
      if (n == 2 && r.op == fsq_pkg::OP_UNPROT) chk("blk_prot", 4'hf, blk_prot);
      if (n == 2) chk("cmd_ready", 1'b0, cmd_ready);
      if (n == 2) chk("busy", 1'b1, busy);
      @(negedge clk);
      n++;
    end
    chk("cmd_err", r.err, cmd_err);
    chk("cmd_cycles", r.n, n);
  endtask
  // One read from the processor or the programmer port
  task automatic rd(input logic ext, input logic [16:0] a, input logic [31:0] e,
                    input logic dn);
    int n;
    cpu_req = !ext;
    ext_req = ext;
    cpu_addr = a;
    ext_addr = a;
    while (!rd_ready) @(negedge clk);
    @(negedge clk);
    cpu_req = 1'b0;
    ext_req = 1'b0;
    n = 1;
    chk("arr_rd_en", dn ? 2'b00 : 2'b01 << a[0], arr_rd_en);
    while (!(cpu_rvalid | ext_rvalid | ext_denied) && n < 9) begin
      @(negedge clk);
      n++;
    end
    chk("rd_cycles", dn ? 1 : 3, n);
    chk("rd_path", dn ? 3'b100 : ext ? 3'b010 : 3'b001,
        {ext_denied, ext_rvalid, cpu_rvalid});
    if (!dn) chk("rd_data", e, rd_data);
  endtask
  // Hang guard, run needs about 800 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    boot(1'b0);
    boot_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk("boot_frozen", 1'b1, boot_from_rom);
    boot(1'b1);
    foreach (rows[i]) begin
      cmd(rows[i]);
      rd(1'b0, rows[i].ra, rows[i].re, 1'b0);
    end
    // Protect block by block; refusals once any block is locked
    for (int i = 0; i < 4; i++) begin
      cmd('{fsq_pkg::OP_PROT, 17'(i) << 15, 32'h0, 1'b0, 2, 17'h0, 32'h0});
      chk("read_prot", 1'(i == 3), read_prot);
      if (i == 0) begin
        cmd('{fsq_pkg::OP_PGM, 17'h0_0002, 32'h0, 1'b1, 1, 17'h0, 32'h0});
        cmd('{fsq_pkg::OP_ERS_CHIP, 17'h0, 32'h0, 1'b1, 1, 17'h0, 32'h0});
      end
    end
    rd(1'b1, 17'h0_0000, 32'h0, 1'b1);
    rd(1'b0, 17'h0_0000, 32'h1234_5678, 1'b0);
    // Unprotect wipes the array before the bits drop
    cmd('{fsq_pkg::OP_UNPROT, 17'h0, 32'h0, 1'b0, int'(EC) + 2, 17'h0, 32'h0});
    chk("blk_prot", 4'h0, blk_prot);
    rd(1'b1, 17'h0_0000, BLANK, 1'b0);
    // A chip erase that is allowed wipes a freshly programmed odd word
    cmd('{fsq_pkg::OP_PGM, 17'h0_0003, 32'h0f0f_f0f0, 1'b0, 152, 17'h0, 32'h0});
    rd(1'b0, 17'h0_0003, 32'h0f0f_f0f0, 1'b0);
    cmd('{fsq_pkg::OP_ERS_CHIP, 17'h0, 32'h0, 1'b0, int'(EC) + 2, 17'h0, 32'h0});
    rd(1'b0, 17'h0_0003, BLANK, 1'b0);
    summarize();
  end
endmodule
